// ===== hdl/lrc_defs.vh
// Offsets, field positions, reset values and codes of the light result and configuration registers
`ifndef LRC_DEFS_VH
`define LRC_DEFS_VH
`define LRC_OFS_RESULT 8'h00
`define LRC_OFS_CONFIG 8'h01
`define LRC_CFG_RESET 16'hc810
`define LRC_RES_RESET 16'h0000
`define LRC_EXP_MSB 15
`define LRC_EXP_LSB 12
`define LRC_MANT_MSB 11
`define LRC_MANT_LSB 0
`define LRC_CFG_CT 11
`define LRC_CFG_MODE_MSB 10
`define LRC_CFG_MODE_LSB 9
`define LRC_CFG_OVF 8
`define LRC_CFG_CRF 7
`define LRC_CFG_FH 6
`define LRC_CFG_FL 5
`define LRC_CFG_ME 2
`define LRC_RANGE_AUTO 4'hc
`define LRC_EXP_MAX 4'hb
`define LRC_MODE_OFF 2'h0
`define LRC_MODE_SINGLE 2'h1
`define LRC_BITS_PER_BYTE 4'h8
`endif

// ===== hdl/lrc_light_regs.v
// Result and configuration registers of the light sensor with their two-wire serial slave
`timescale 1ns/1ps
`include "lrc_defs.vh"

// How it works
// [RL1] The result word carries a 4-bit exponent in bits 15..12 and a 12-bit mantissa in bits 11..0.
// [RL2] The result register holds the last completed conversion and is replaced when the next one finishes.
// [RL3] The mantissa is an unsigned straight-binary count from zero up to full scale.
// [RL4] Lux equals 0.01 times two to the exponent times the mantissa, for the device and the reader alike.
// [RL5] Only exponent codes 0 to 11 are reported, full scale doubling per code from 40.95 to 83865.60 lux.
// [RL6] With the exponent mask set and a manual range below 12, the reported exponent is zero.
// [RL7] A configuration write during a running conversion aborts that conversion at once.
// [RL8] If the written configuration asks for conversions, a fresh one starts in the same cycle as the abort.
// [RL9] The configuration register sits at offset 01h, has eleven fields and resets to C810h.
// [RL10] Configuration bits 15..9 and 4..0 are read/write, bits 8..5 are read-only.
// [RL11] The result register at offset 00h is read-only and ignores writes.
// [RL12] Each register crosses the serial bus as two bytes, upper byte first.
// [RL13] Every register is 16 bits wide.
// [RL14] Exponent and mantissa are updated together so a read never mixes two conversions.
module lrc_light_regs (
    input wire ref_clk,
    input wire nrst,
    input wire [6:0] dev_addr,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_n_q,
    input wire conv_done,
    input wire [3:0] conv_exp,
    input wire [11:0] conv_mant,
    input wire conv_overflow,
    input wire high_limit_hit,
    input wire low_limit_hit,
    output reg conv_start_q,
    output reg conv_abort_q,
    output wire [3:0] range_select,
    output wire conv_time_long,
    output wire exponent_mask
);
    localparam ST_IDLE = 4'h0;
    localparam ST_ADDR = 4'h1;
    localparam ST_ADDR_ACK = 4'h2;
    localparam ST_PTR = 4'h3;
    localparam ST_PTR_ACK = 4'h4;
    localparam ST_WDATA = 4'h5;
    localparam ST_WDATA_ACK = 4'h6;
    localparam ST_RDATA = 4'h7;
    localparam ST_RDATA_ACK = 4'h8;

    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg [3:0] st_q;
    reg [3:0] cnt_q;
    reg [7:0] rx_q;
    reg [7:0] tx_q;
    reg [7:0] ptr_q;
    reg [7:0] msb_hold_q;
    reg [15:0] rd_hold_q;
    reg byte_lo_q;
    reg rw_q;
    reg mack_q;
    reg cfg_wr_q;
    reg [15:0] cfg_wdata_q;
    reg crf_clr_q;
    reg [15:0] result_q;
    reg [15:0] cfg_rw_q;
    reg ovf_q;
    reg crf_q;
    reg busy_q;
    reg [3:0] exp_sel;
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_s_q[2];
    wire scl_fall = ~scl & scl_s_q[2];
    wire start_cond = scl & scl_s_q[2] & ~sda & sda_s_q[2];
    wire stop_cond = scl & scl_s_q[2] & sda & ~sda_s_q[2];
    wire [15:0] cfg_view;
    wire [15:0] rd_word;
    wire [1:0] mode = cfg_rw_q[`LRC_CFG_MODE_MSB:`LRC_CFG_MODE_LSB];
    wire [1:0] new_mode = cfg_wdata_q[`LRC_CFG_MODE_MSB:`LRC_CFG_MODE_LSB];

    assign range_select = cfg_rw_q[`LRC_EXP_MSB:`LRC_EXP_LSB];
    assign conv_time_long = cfg_rw_q[`LRC_CFG_CT];
    assign exponent_mask = cfg_rw_q[`LRC_CFG_ME];
    assign sda_out = 1'b0;

    // Bits 8..5 come from live status, the rest from the writable store
    assign cfg_view = {cfg_rw_q[15:9], ovf_q, crf_q, high_limit_hit, low_limit_hit, cfg_rw_q[4:0]}; // see [RL10]
    assign rd_word = (ptr_q == `LRC_OFS_RESULT) ? result_q :
                     (ptr_q == `LRC_OFS_CONFIG) ? cfg_view : 16'h0000; // see [RL13]

    // Manual range reports the programmed code, or zero with the exponent mask set; automatic mode clamps to the top code
    always @* begin
        if (range_select < `LRC_RANGE_AUTO) begin
            exp_sel = exponent_mask ? 4'h0 : range_select; // see [RL6]
        end else begin
            exp_sel = (conv_exp > `LRC_EXP_MAX) ? `LRC_EXP_MAX : conv_exp; // see [RL5]
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_in};
            sda_s_q <= {sda_s_q[1:0], sda_in};
        end
    end

    // Serial slave: receive on rising clock, drive on falling clock
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            msb_hold_q <= 8'h00;
            rd_hold_q <= 16'h0000;
            byte_lo_q <= 1'b0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            cfg_wr_q <= 1'b0;
            cfg_wdata_q <= 16'h0000;
            crf_clr_q <= 1'b0;
        end else begin
            cfg_wr_q <= 1'b0;
            crf_clr_q <= 1'b0;
            if (start_cond) begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe_n_q <= 1'b1;
            end else if (stop_cond) begin
                st_q <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
            end else if (scl_rise) begin
                if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDATA) begin
                    rx_q <= {rx_q[6:0], sda};
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == ST_RDATA_ACK) begin
                    mack_q <= ~sda;
                end
            end else if (scl_fall) begin
                case (st_q)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (cnt_q == `LRC_BITS_PER_BYTE) begin
                            cnt_q <= 4'h0;
                            if (st_q == ST_ADDR) begin
                                if (rx_q[7:1] == dev_addr) begin
                                    rw_q <= rx_q[0];
                                    byte_lo_q <= 1'b0;
                                    sda_oe_n_q <= 1'b0;
                                    st_q <= ST_ADDR_ACK;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else if (st_q == ST_PTR) begin
                                ptr_q <= rx_q;
                                sda_oe_n_q <= 1'b0;
                                st_q <= ST_PTR_ACK;
                            end else begin
                                if (!byte_lo_q) begin
                                    msb_hold_q <= rx_q; // see [RL12]
                                end else if (ptr_q == `LRC_OFS_CONFIG) begin
                                    cfg_wr_q <= 1'b1; // see [RL11]
                                    cfg_wdata_q <= {msb_hold_q, rx_q};
                                end
                                sda_oe_n_q <= 1'b0;
                                st_q <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (rw_q) begin
                            // Whole word is captured once so both bytes belong to one update
                            rd_hold_q <= rd_word; // see [RL14]
                            tx_q <= rd_word[15:8]; // see [RL12]
                            crf_clr_q <= (ptr_q == `LRC_OFS_CONFIG);
                            sda_oe_n_q <= rd_word[15];
                            cnt_q <= 4'h0;
                            st_q <= ST_RDATA;
                        end else begin
                            sda_oe_n_q <= 1'b1;
                            st_q <= ST_PTR;
                        end
                    end
                    ST_PTR_ACK, ST_WDATA_ACK: begin
                        if (st_q == ST_WDATA_ACK) begin
                            byte_lo_q <= ~byte_lo_q;
                        end
                        sda_oe_n_q <= 1'b1;
                        st_q <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (cnt_q == 4'h7) begin
                            sda_oe_n_q <= 1'b1;
                            st_q <= ST_RDATA_ACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_n_q <= tx_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (mack_q) begin
                            if (byte_lo_q) begin
                                rd_hold_q <= rd_word; // see [RL14]
                                tx_q <= rd_word[15:8]; // see [RL12]
                                sda_oe_n_q <= rd_word[15];
                                crf_clr_q <= (ptr_q == `LRC_OFS_CONFIG);
                            end else begin
                                // Low byte from the capture, never from the live word
                                tx_q <= rd_hold_q[7:0]; // see [RL14]
                                sda_oe_n_q <= rd_hold_q[7];
                            end
                            byte_lo_q <= ~byte_lo_q;
                            cnt_q <= 4'h0;
                            st_q <= ST_RDATA;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Conversion control and register store
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rw_q <= `LRC_CFG_RESET; // see [RL9]
            ovf_q <= 1'b0;
            crf_q <= 1'b0;
            result_q <= `LRC_RES_RESET;
            busy_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_abort_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            conv_abort_q <= 1'b0;
            if (cfg_wr_q) begin
                cfg_rw_q <= {cfg_wdata_q[15:9], 4'h0, cfg_wdata_q[4:0]}; // see [RL10]
                conv_abort_q <= busy_q; // see [RL7]
                busy_q <= (new_mode != `LRC_MODE_OFF);
                conv_start_q <= (new_mode != `LRC_MODE_OFF); // see [RL8]
            end else if (busy_q && conv_done) begin
                result_q <= {exp_sel, conv_mant}; // see [RL1] [RL2] [RL3] [RL4] [RL14]
                ovf_q <= conv_overflow;
                if (mode == `LRC_MODE_SINGLE) begin
                    cfg_rw_q[`LRC_CFG_MODE_MSB:`LRC_CFG_MODE_LSB] <= `LRC_MODE_OFF;
                    busy_q <= 1'b0;
                end else begin
                    conv_start_q <= 1'b1;
                end
            end
            // A finishing conversion wins over a ready-flag clear in the same cycle
            // Clear only a flag the host has actually been shown in its capture
            if (busy_q && conv_done && !cfg_wr_q) begin
                crf_q <= 1'b1;
            end else if (crf_clr_q && rd_hold_q[`LRC_CFG_CRF]) begin
                crf_q <= 1'b0;
            end
        end
    end
endmodule // lrc_light_regs

// ===== testbench/lrc_light_regs_chk.sv
// Assertion checker for the light result and configuration registers
`timescale 1ns/1ps
module lrc_light_regs_chk (
    input wire ref_clk,
    input wire nrst,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_n_q,
    input wire conv_done,
    input wire conv_start_q,
    input wire conv_abort_q,
    input wire [3:0] range_select
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_drive_high;
        !sda_oe_n_q && scl_in;
    endsequence
    a_reset_range: assert property ($rose(nrst) |-> range_select == 4'hc)
        else $error("range wrong after reset");
    a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
        else $error("start pulse too long");
    a_abort_pulse: assert property (conv_abort_q |=> !conv_abort_q)
        else $error("abort pulse too long");
    a_start_cause: assert property (conv_start_q |-> $past(conv_done) || !scl_in)
        else $error("start without cause");
    a_abort_cause: assert property (conv_abort_q |-> !scl_in && !$past(conv_done))
        else $error("abort without config write");
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin not open drain");
    a_drive_edge: assert property ($fell(sda_oe_n_q) |-> !scl_in)
        else $error("data driven while clock high");
    a_data_stands: assert property (s_drive_high |=> !sda_oe_n_q)
        else $error("data released while clock high");
endmodule // lrc_light_regs_chk

bind lrc_light_regs lrc_light_regs_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n_q(sda_oe_n_q), .conv_done(conv_done), .conv_start_q(conv_start_q),
    .conv_abort_q(conv_abort_q), .range_select(range_select));

// ===== testbench/lrc_host_model.sv
// Two-wire bus host model on the far side of the register block
`timescale 1ns/1ps
module lrc_host_model #(parameter [6:0] ADDR = 7'h45) (
    input wire ref_clk,
    input wire sda,
    output reg scl = 1'b1,
    output reg sda_rel = 1'b1
);
    integer nak_cnt = 0;
    reg a;
    reg [7:0] t;
    task q;
        repeat (8) @(negedge ref_clk);
    endtask
    // Data moves only while the clock is low, sampled mid-high
    task bit_io(input b);
        sda_rel = b;
        q;
        scl = 1'b1;
        q;
        a = sda;
        q;
        scl = 1'b0;
        q;
    endtask
    task byte_io(input [7:0] b, input ack, output [7:0] r);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(b[i]);
            r[i] = a;
        end
        bit_io(ack);
        if (ack && a && b != 8'hff) nak_cnt = nak_cnt + 1;
    endtask
    // Works as a first or a repeated start: release data, raise clock, then pull data low
    task start_c;
        sda_rel = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_rel = 1'b0;
        q;
        scl = 1'b0;
        q;
    endtask
    task stop_c;
        sda_rel = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_rel = 1'b1;
        q;
    endtask
    task wr_reg(input [7:0] p, input [15:0] d, input data);
        start_c;
        byte_io({ADDR, 1'b0}, 1'b1, t);
        byte_io(p, 1'b1, t);
        if (data) byte_io(d[15:8], 1'b1, t);
        if (data) byte_io(d[7:0], 1'b1, t);
        stop_c;
    endtask
    task rd_reg(input [7:0] p, output [15:0] d);
        wr_reg(p, 16'h0000, 1'b0);
        start_c;
        byte_io({ADDR, 1'b1}, 1'b1, t);
        byte_io(8'hff, 1'b0, d[15:8]);
        byte_io(8'hff, 1'b1, d[7:0]);
        stop_c;
    endtask
endmodule // lrc_host_model

// ===== testbench/testbench.sv
// Self-checking bench for the light result and configuration registers
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0;
    reg nrst = 1'b0;
    reg conv_done = 1'b0;
    reg [3:0] conv_exp = 4'h0;
    reg [11:0] conv_mant = 12'h000;
    reg hi_hit = 1'b0;
    reg lo_hit = 1'b0;
    reg ovf_in = 1'b0;
    wire scl, sda_rel, sda_out, sda_oe_n_q, conv_start_q, conv_abort_q, ct_long, ex_mask;
    wire [3:0] range_select;
    wire sda = sda_rel & (sda_oe_n_q | sda_out);
    integer error_cnt = 0, check_count = 0, n_start = 0, n_abort = 0, n_both = 0;
    reg [15:0] rd;
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_start <= n_start + {31'h0, conv_start_q};
        n_abort <= n_abort + {31'h0, conv_abort_q};
        n_both <= n_both + {31'h0, conv_start_q & conv_abort_q};
    end
    lrc_light_regs u_dut (.ref_clk(ref_clk), .nrst(nrst), .dev_addr(7'h45), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n_q(sda_oe_n_q), .conv_done(conv_done), .conv_exp(conv_exp),
        .conv_mant(conv_mant), .conv_overflow(ovf_in), .high_limit_hit(hi_hit), .low_limit_hit(lo_hit),
        .conv_start_q(conv_start_q), .conv_abort_q(conv_abort_q), .range_select(range_select),
        .conv_time_long(ct_long), .exponent_mask(ex_mask));
    lrc_host_model #(.ADDR(7'h45)) u_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    task chk(input [63:0] nm, input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task rdc(input [63:0] nm, input [7:0] p, input [15:0] e);
        u_host.rd_reg(p, rd);
        chk(nm, rd, e);
    endtask
    task conv(input [15:0] v, input ov);
        @(negedge ref_clk);
        {conv_exp, conv_mant} = v;
        ovf_in = ov;
        conv_done = 1'b1;
        @(negedge ref_clk);
        conv_done = 1'b0;
    endtask
    task t_reset;
        rdc("config", 8'h01, 16'hc810);
        rdc("result", 8'h00, 16'h0000);
        $display("reset test done");
    endtask
    task t_single;
        hi_hit = 1'b1;
        lo_hit = 1'b1;
        u_host.wr_reg(8'h01, 16'h33f5, 1'b1);
        chk("starts", n_start[15:0], 16'h0001);
        chk("fields", {10'h000, range_select, ct_long, ex_mask}, 16'h000d);
        rdc("config", 8'h01, 16'h3275);
        conv(16'h789a, 1'b1);
        rdc("masked", 8'h00, 16'h089a);
        rdc("ready", 8'h01, 16'h31f5);
        u_host.wr_reg(8'h00, 16'hffff, 1'b1);
        rdc("readonly", 8'h00, 16'h089a);
        $display("single shot test done");
    endtask
    task t_auto;
        u_host.wr_reg(8'h01, 16'hc610, 1'b1);
        conv(16'hbfff, 1'b0);
        rdc("full", 8'h00, 16'hbfff);
        u_host.wr_reg(8'h01, 16'hc610, 1'b1);
        chk("both", n_both[15:0], 16'h0001);
        conv(16'h3456, 1'b0);
        rdc("scaled", 8'h00, 16'h3456);
        conv(16'hf123, 1'b0);
        rdc("clamped", 8'h00, 16'hb123);
        u_host.wr_reg(8'h01, 16'hc010, 1'b1);
        u_host.wr_reg(8'h01, 16'h5210, 1'b1);
        conv(16'h0abc, 1'b0);
        rdc("manual", 8'h00, 16'h5abc);
        chk("aborts", n_abort[15:0], 16'h0002);
        chk("starts", n_start[15:0], 16'h0007);
        chk("naks", u_host.nak_cnt[15:0], 16'h0000);
        $display("continuous test done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset;
        t_single;
        t_auto;
        tally_and_finish;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule // testbench
